/* File: rtl/uart_event_mask_logic.sv */
// UART channel event flags, mask, control-character match and transmit freeze/pacing
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// Contract
// - 8-bit sticky event register, set on events
// - Event register read has no side effect
// - Write one clears bit, zero untouched
// - Request held until unmasked events cleared
// - Reset zeroes event register
// - Bit order CTS..RX from 7 to 0
// - CTS/CD any edge sets change bit
// - Receive idle change sets idle bit
// - Break character sets break bit
// - Rejected control char stored, event set
// - No empty buffer: drop char, busy
// - Busy in multidrop returns to hunt
// - Report set: TX event at last bit
// - Report clear: TX event at FIFO write
// - RX event no earlier than mid-stop
// - 8-bit read-write mask, one enables
// - Reset clears mask register
// - Non-reject control char closes buffer
// - Rejected control char not stored
// - Freeze halts, release resumes losslessly
// - Report set: two idle bits between buffers
module uart_event_mask_logic
  import uart_evt_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Control-character table port (software side)
  input wire logic i_ct_write,
  input wire logic [2:0] i_ct_index,
  input wire logic [9:0] i_ct_entry,
  output logic [7:0] o_last_ctrl_char,
  // Modem lines from pins (asynchronous)
  input wire logic i_cts_n,
  input wire logic i_cd_n,
  // Receive framing path (same clock)
  input wire logic i_rx_valid,
  input wire rx_char_t i_rx_char,
  input wire logic i_rx_mid_stop,
  input wire logic i_rx_line_idle,
  input wire logic i_rx_buf_empty_avail,
  output logic o_rx_store,
  output logic [7:0] o_rx_store_data,
  output logic o_rx_close_buf,
  output logic o_rx_hunt,
  // Transmit path
  input wire logic i_tx_valid,
  input wire tx_char_t i_tx_char,
  output logic o_tx_ready,
  input wire logic i_tx_last_bit_start,
  output logic o_tx_fifo_wr,
  output logic [7:0] o_tx_fifo_data,
  input wire logic i_tx_fifo_full,
  output logic o_irq
);

  logic [7:0] event_r, event_nxt, set_ev;
  logic [7:0] enable_r;
  logic [3:0] control_r;
  logic [9:0] ctable_r [CT_ENTRIES];
  logic [7:0] last_cc_r;
  logic [2:0] cts_sync_r, cd_sync_r;
  logic cts_lvl_r, cd_lvl_r, idle_lvl_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic rx_store_r, rx_close_r, rx_hunt_r;
  logic [7:0] rx_data_r;
  logic close_pend_r;
  logic tx_pend_done_r;
  logic tx_wr_r;
  logic [7:0] tx_data_r;
  logic [CTR_W-1:0] gap_cnt_r;
  logic gap_active_r;

  typedef enum {TX_IDLE, TX_GAP} tx_state_t;
  tx_state_t tx_state_r;

  logic acc, wr_acc, rd_acc;
  assign acc = (i_avs_read | i_avs_write) & wait_r;
  assign wr_acc = i_avs_write & wait_r;
  assign rd_acc = i_avs_read & wait_r;

  // One wait cycle then answer: request seen, waitrequest drops next edge
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= (i_avs_read | i_avs_write) & ~wait_r;
    end
  end

  // Read data, no side effect on event state
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_r <= UNMAPPED_READ;
    end else if (i_avs_read & ~wait_r) begin
      case (i_avs_address)
        ADDR_EVENT_FLAGS: rdata_r <= {24'h00_0000, event_r};
        ADDR_EVENT_ENABLE: rdata_r <= {24'h00_0000, enable_r};
        ADDR_LINE_STATUS: rdata_r <= {29'h0000_0000, idle_lvl_r, cd_lvl_r, cts_lvl_r};
        ADDR_CONTROL: rdata_r <= {28'h000_0000, control_r};
        // Unmapped offsets read zero, never an error
        default: rdata_r <= UNMAPPED_READ;
      endcase
    end
  end

  // Control and mask registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      enable_r <= ENABLE_RESET;
      control_r <= CONTROL_RESET;
    end else if (wr_acc) begin
      if (i_avs_address == ADDR_EVENT_ENABLE) begin
        enable_r <= i_avs_writedata[7:0];
      end
      if (i_avs_address == ADDR_CONTROL) begin
        control_r <= i_avs_writedata[3:0];
      end
    end
  end

  // Control-character table
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      for (int i = 0; i < CT_ENTRIES; i++) begin
        ctable_r[i] <= 10'h000;
      end
    end else if (i_ct_write) begin
      ctable_r[i_ct_index] <= i_ct_entry;
    end
  end

  // Modem lines: three flops, change once second and third agree
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cts_sync_r <= 3'h0;
      cd_sync_r <= 3'h0;
      cts_lvl_r <= 1'b0;
      cd_lvl_r <= 1'b0;
    end else begin
      cts_sync_r <= {cts_sync_r[1:0], i_cts_n};
      cd_sync_r <= {cd_sync_r[1:0], i_cd_n};
      if (cts_sync_r[1] == cts_sync_r[2]) begin
        cts_lvl_r <= cts_sync_r[2];
      end
      if (cd_sync_r[1] == cd_sync_r[2]) begin
        cd_lvl_r <= cd_sync_r[2];
      end
    end
  end

  // Receive idle level comes from same-clock logic, no synchroniser
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      idle_lvl_r <= 1'b0;
    end else begin
      idle_lvl_r <= i_rx_line_idle;
    end
  end

  // Control-character match over the table
  // Lowest index wins when two entries hold one char
  logic cc_hit, cc_reject;
  always_comb begin
    cc_hit = 1'b0;
    cc_reject = 1'b0;
    for (int i = 0; i < CT_ENTRIES; i++) begin
      if (ctable_r[i][CT_VALID] && ctable_r[i][7:0] == i_rx_char.data && !cc_hit) begin
        cc_hit = 1'b1;
        cc_reject = ctable_r[i][CT_REJECT];
      end
    end
  end

  // Breaks skip the table and never take a buffer
  logic rx_take, rx_busy;
  assign rx_take = i_rx_valid & control_r[CTL_RX_ON] & ~i_rx_char.is_break;
  assign rx_busy = rx_take & ~(cc_hit & cc_reject) & ~i_rx_buf_empty_avail;

  // Receive side: store, close, hunt
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_store_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_hunt_r <= 1'b0;
      close_pend_r <= 1'b0;
    end else begin
      // Rejected control chars never reach the buffer
      rx_store_r <= rx_take & ~(cc_hit & cc_reject) & i_rx_buf_empty_avail;
      rx_data_r <= i_rx_char.data;
      rx_hunt_r <= rx_busy & control_r[CTL_MULTIDROP];
      // Close waits for mid-stop so the RX event is never early
      if (rx_take & cc_hit & ~cc_reject & i_rx_buf_empty_avail) begin
        close_pend_r <= 1'b1;
      end else if (i_rx_mid_stop) begin
        close_pend_r <= 1'b0;
      end
    end
  end

  // Last rejected control char, kept for software
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      last_cc_r <= 8'h00;
    end else if (rx_take & cc_hit & cc_reject) begin
      last_cc_r <= i_rx_char.data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_close_r <= 1'b0;
    end else begin
      rx_close_r <= close_pend_r & i_rx_mid_stop;
    end
  end

  // Transmit: freeze stalls the source, no character dropped
  logic tx_go;
  assign tx_go = i_tx_valid & o_tx_ready;

  // Ready drops after each take: at most one char per two clocks
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= control_r[CTL_TX_ON] & ~control_r[CTL_FREEZE] & ~i_tx_fifo_full
        & (tx_state_r == TX_IDLE) & ~tx_go;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_wr_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else begin
      tx_wr_r <= tx_go;
      if (tx_go) begin
        tx_data_r <= i_tx_char.data;
      end
    end
  end

  // Buffer end pacing: two idle bit times when reporting is on
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_state_r <= TX_IDLE;
      gap_cnt_r <= '0;
      tx_pend_done_r <= 1'b0;
      gap_active_r <= 1'b0;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          if (tx_go & i_tx_char.last_in_buf & i_tx_char.clear_send_report) begin
            tx_state_r <= TX_GAP;
            tx_pend_done_r <= 1'b1;
            gap_active_r <= 1'b0;
            gap_cnt_r <= CTR_W'(BIT_CYCLES * IDLE_GAP_BITS);
          end
        end
        TX_GAP: begin
          if (tx_pend_done_r) begin
            if (i_tx_last_bit_start) begin
              tx_pend_done_r <= 1'b0;
              gap_active_r <= 1'b1;
              // Last data bit plus stop bit still to go before the idles
              gap_cnt_r <= CTR_W'(BIT_CYCLES * (IDLE_GAP_BITS + 2'h2));
            end
          end else if (gap_cnt_r == '0) begin
            tx_state_r <= TX_IDLE;
            gap_active_r <= 1'b0;
          end else begin
            gap_cnt_r <= gap_cnt_r - 1'b1;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // Pin synchronisers refill after reset; a level seen then is no change
  logic [2:0] settle_cnt_r;
  logic edges_armed;
  assign edges_armed = (settle_cnt_r == EDGE_SETTLE_CYCLES);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      settle_cnt_r <= 3'h0;
    end else if (!edges_armed) begin
      settle_cnt_r <= settle_cnt_r + 3'h1;
    end
  end

  // Event sources
  logic cts_prev_r, cd_prev_r, idle_prev_r;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cts_prev_r <= 1'b0;
      cd_prev_r <= 1'b0;
      idle_prev_r <= 1'b0;
    end else begin
      cts_prev_r <= cts_lvl_r;
      cd_prev_r <= cd_lvl_r;
      idle_prev_r <= idle_lvl_r;
    end
  end

  always_comb begin
    set_ev = 8'h00;
    set_ev[EV_CTS] = edges_armed & (cts_prev_r ^ cts_lvl_r);
    set_ev[EV_CD] = edges_armed & (cd_prev_r ^ cd_lvl_r);
    set_ev[EV_IDLE] = edges_armed & (idle_prev_r ^ idle_lvl_r);
    set_ev[EV_BRK] = i_rx_valid & control_r[CTL_RX_ON] & i_rx_char.is_break;
    set_ev[EV_CCR] = rx_take & cc_hit & cc_reject;
    set_ev[EV_BUSY] = rx_busy;
    set_ev[EV_TX] = (tx_go & i_tx_char.last_in_buf & ~i_tx_char.clear_send_report)
      | (tx_state_r == TX_GAP & tx_pend_done_r & i_tx_last_bit_start);
    set_ev[EV_RX] = close_pend_r & i_rx_mid_stop;
  end

  // Sticky flags: set wins over the write-one clear
  always_comb begin
    event_nxt = event_r;
    if (wr_acc && i_avs_address == ADDR_EVENT_FLAGS) begin
      event_nxt = event_r & ~i_avs_writedata[7:0];
    end
    event_nxt = event_nxt | set_ev;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      event_r <= EVENT_RESET;
    end else begin
      event_r <= event_nxt;
    end
  end

  // Follows the flags in the same clock; set beats clear, so no event is missed
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(event_nxt & enable_r);
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = ~wait_r;
  assign o_irq = irq_r;
  assign o_last_ctrl_char = last_cc_r;
  assign o_rx_store = rx_store_r;
  assign o_rx_store_data = rx_data_r;
  assign o_rx_close_buf = rx_close_r;
  assign o_rx_hunt = rx_hunt_r;
  assign o_tx_fifo_wr = tx_wr_r;
  assign o_tx_fifo_data = tx_data_r;

  logic unused;
  assign unused = acc | rd_acc | gap_active_r;
endmodule

/* File: rtl/uart_evt_pkg.sv */
// Package: register map, event bit layout and timing constants for the UART event block
package uart_evt_pkg;
  // Register byte addresses (word aligned)
  localparam logic [3:0] ADDR_EVENT_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_EVENT_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_LINE_STATUS = 4'h8;
  localparam logic [3:0] ADDR_CONTROL = 4'hc;
  localparam logic [3:0] ADDR_LAST_CTRL_CHAR = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TABLE = 4'h4;
  // Event bit positions
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_BUSY = 2;
  localparam int EV_CCR = 3;
  localparam int EV_BRK = 4;
  localparam int EV_IDLE = 5;
  localparam int EV_CD = 6;
  localparam int EV_CTS = 7;
  // Control register bit positions
  localparam int CTL_FREEZE = 0;
  localparam int CTL_TX_ON = 1;
  localparam int CTL_RX_ON = 2;
  localparam int CTL_MULTIDROP = 3;
  // Control table entry layout: [9]=valid, [8]=reject, [7:0]=char
  localparam int CT_VALID = 9;
  localparam int CT_REJECT = 8;
  localparam int CT_ENTRIES = 8;
  // Reset values
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Bit timing
  localparam int CLOCK_HZ = 10_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES = CLOCK_HZ / BAUD;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int CTR_W = 13;
  // Clocks after reset before pin edges count as events
  localparam logic [2:0] EDGE_SETTLE_CYCLES = 3'h5;
  // Idle gap between back-to-back buffers when clear_send_report is set
  localparam logic [1:0] IDLE_GAP_BITS = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic last_in_buf;
    logic clear_send_report;
  } tx_char_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_break;
  } rx_char_t;
endpackage

/* File: sim/uart_event_mask_logic_sva.sv */
// Checker: port-level assertions for the UART event block
`timescale 1ns/1ps
module uart_event_mask_logic_sva
  import uart_evt_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic i_rx_valid,
  input wire rx_char_t i_rx_char,
  input wire logic i_rx_mid_stop,
  input wire logic i_rx_buf_empty_avail,
  input wire logic o_rx_store,
  input wire logic [7:0] o_rx_store_data,
  input wire logic o_rx_close_buf,
  input wire logic o_rx_hunt,
  input wire logic i_tx_valid,
  input wire tx_char_t i_tx_char,
  input wire logic o_tx_ready,
  input wire logic o_tx_fifo_wr,
  input wire logic [7:0] o_tx_fifo_data,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  property p_rst; $fell(i_srst) |-> !o_irq; endproperty
  a_rst: assert property (p_rst) else $error("irq high after reset");
  property p_ans; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_hold; o_irq && !i_avs_write && !$past(i_avs_write) |=> o_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped without a write");
  property p_mask;
    i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_EVENT_ENABLE && i_avs_writedata[7:0] == 8'h00
      |=> ##1 !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with all masked");
  property p_store;
    o_rx_store |-> $past(i_rx_valid) && $past(i_rx_buf_empty_avail) && o_rx_store_data == $past(i_rx_char.data);
  endproperty
  a_store: assert property (p_store) else $error("bad store");
  property p_hunt; o_rx_hunt |-> $past(i_rx_valid && !i_rx_buf_empty_avail); endproperty
  a_hunt: assert property (p_hunt) else $error("hunt without busy");
  property p_close; o_rx_close_buf |-> $past(i_rx_mid_stop); endproperty
  a_close: assert property (p_close) else $error("close before mid stop");
  property p_fifo; i_tx_valid && o_tx_ready |=> o_tx_fifo_wr && o_tx_fifo_data == $past(i_tx_char.data); endproperty
  a_fifo: assert property (p_fifo) else $error("fifo write missing");
  c_irq: cover property ($rose(o_irq));
  c_hunt: cover property (o_rx_hunt);
  c_close: cover property (o_rx_close_buf);
endmodule
bind uart_event_mask_logic uart_event_mask_logic_sva uart_event_mask_logic_sva_i (.*);

/* File: sim/uart_event_mask_logic_tb.sv */
// Testbench: registers, events, masking and transmit pacing
`timescale 1ns/1ps
module uart_event_mask_logic_tb;
  import uart_evt_pkg::*;
  typedef struct {int k; logic [7:0] e;} row_t;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic rd = 1'b0, wr = 1'b0, ctw = 1'b0, avail = 1'b1, txv = 1'b0, lbs = 1'b0, full = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, q, rdata;
  logic [2:0] cti = 3'h0;
  logic [9:0] cte = 10'h000;
  tx_char_t txc = '0;
  wire logic cts_n, cd_n, rxv, mid, idle;
  wire rx_char_t rxc;
  logic waitr, store, close, hunt, txr, fwr, irq;
  logic [7:0] sdata, lcc, fdata, fifo_d, sd;
  int num_errors = 0, checks = 0, stores = 0, hunts = 0, fifo_n = 0, closes = 0, n;
  row_t rows[8] = '{'{EV_CTS, 8'h80}, '{EV_CD, 8'h40}, '{EV_IDLE, 8'h20}, '{EV_BRK, 8'h10},
                    '{EV_CCR, 8'h08}, '{EV_BUSY, 8'h04}, '{EV_TX, 8'h02}, '{EV_RX, 8'h01}};
  always #50 i_clock = ~i_clock;
  uart_event_mask_logic uart_event_mask_logic_i (.i_clock(i_clock), .i_srst(i_srst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(waitr),
    .i_ct_write(ctw), .i_ct_index(cti), .i_ct_entry(cte), .o_last_ctrl_char(lcc), .i_cts_n(cts_n), .i_cd_n(cd_n),
    .i_rx_valid(rxv), .i_rx_char(rxc), .i_rx_mid_stop(mid), .i_rx_line_idle(idle), .i_rx_buf_empty_avail(avail),
    .o_rx_store(store), .o_rx_store_data(sdata), .o_rx_close_buf(close), .o_rx_hunt(hunt), .i_tx_valid(txv),
    .i_tx_char(txc), .o_tx_ready(txr), .i_tx_last_bit_start(lbs), .o_tx_fifo_wr(fwr), .o_tx_fifo_data(fdata),
    .i_tx_fifo_full(full), .o_irq(irq));
  uart_far_station #(.MID_GAP(6)) uart_far_station_i (.i_clock(i_clock), .o_cts_n(cts_n), .o_cd_n(cd_n),
    .o_rx_valid(rxv), .o_rx_char(rxc), .o_rx_mid_stop(mid), .o_rx_line_idle(idle));
  always @(negedge i_clock) begin
    if (store === 1'b1) begin
      stores++;
      sd = sdata;
    end
    if (close === 1'b1) closes++;
    if (hunt === 1'b1) hunts++;
    if (fwr === 1'b1) begin
      fifo_n++;
      fifo_d = fdata;
    end
  end
  task stop_test();
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    logic busy;
    @(posedge i_clock);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    busy = 1'b1;
    for (int i = 0; i < 20 && busy; i++) begin
      @(posedge i_clock);
      busy = waitr !== 1'b0;
      if (!busy) r = rdata;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    chk("bus_answer", 0, 32'(busy));
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  task wirq();
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge i_clock);
  endtask
  task irq_is(input logic lv);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk("irq", 32'(lv), 32'(irq));
  endtask
  task ct(input logic [2:0] x, input logic [9:0] e);
    @(posedge i_clock);
    ctw <= 1'b1;
    cti <= x;
    cte <= e;
    @(posedge i_clock);
    ctw <= 1'b0;
  endtask
  task tx_send(input tx_char_t c);
    logic t;
    @(posedge i_clock);
    txv <= 1'b1;
    txc <= c;
    t = 1'b0;
    for (int i = 0; i < 200 && !t; i++) begin
      @(posedge i_clock);
      t = txr === 1'b1;
    end
    txv <= 1'b0;
    txc <= ~c;
    chk("tx_take", 1, 32'(t));
  endtask
  task ev(input int k);
    case (k)
      EV_CTS, EV_CD, EV_IDLE: uart_far_station_i.flip(k);
      EV_BRK: uart_far_station_i.send(8'h00, 1'b1);
      EV_CCR: uart_far_station_i.send(8'h13, 1'b0);
      EV_BUSY: begin
        @(posedge i_clock) avail <= 1'b0;
        uart_far_station_i.send(8'h55, 1'b0);
        @(posedge i_clock) avail <= 1'b1;
      end
      EV_TX: tx_send('{data: 8'h3c, last_in_buf: 1'b1, clear_send_report: 1'b0});
      default: uart_far_station_i.send(8'h0a, 1'b0);
    endcase
  endtask
  initial begin
    repeat (30000) @(posedge i_clock);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_srst <= 1'b0;
    rchk(ADDR_EVENT_FLAGS, 0, "flags_rst");
    rchk(ADDR_EVENT_ENABLE, 0, "enable_rst");
    rchk(4'h2, 0, "unmapped");
    bus(1'b1, ADDR_EVENT_ENABLE, 32'h0000_00ff, q);
    rchk(ADDR_EVENT_ENABLE, 32'h0000_00ff, "enable");
    bus(1'b1, ADDR_CONTROL, 32'h0000_0006, q);
    ct(3'h0, 10'h313);
    ct(3'h1, 10'h20a);
    ct(3'h2, 10'h311);
    foreach (rows[i]) begin
      ev(rows[i].k);
      wirq();
      rchk(ADDR_EVENT_FLAGS, 32'(rows[i].e), "flags");
      rchk(ADDR_EVENT_FLAGS, 32'(rows[i].e), "flags_again");
      bus(1'b1, ADDR_EVENT_FLAGS, 32'h0000_00ff, q);
      rchk(ADDR_EVENT_FLAGS, 0, "flags_clr");
      irq_is(1'b0);
    end
    chk("closes", 1, 32'(closes));
    chk("store_data", 32'h0000_000a, 32'(sd));
    // Two events, partial clear, then masking
    ev(EV_CTS);
    ev(EV_CD);
    wirq();
    bus(1'b1, ADDR_EVENT_FLAGS, 32'h0000_0040, q);
    rchk(ADDR_EVENT_FLAGS, 32'h0000_0080, "partial");
    irq_is(1'b1);
    bus(1'b1, ADDR_EVENT_ENABLE, 32'h0000_007f, q);
    irq_is(1'b0);
    bus(1'b1, ADDR_EVENT_ENABLE, 32'h0000_0000, q);
    irq_is(1'b0);
    bus(1'b1, ADDR_EVENT_ENABLE, 32'h0000_00ff, q);
    irq_is(1'b1);
    bus(1'b1, ADDR_EVENT_FLAGS, 32'h0000_0080, q);
    irq_is(1'b0);
    n = stores;
    uart_far_station_i.send(8'h11, 1'b0);
    chk("last_ctrl", 32'h0000_0011, 32'(lcc));
    chk("no_store", 32'(n), 32'(stores));
    bus(1'b1, ADDR_CONTROL, 32'h0000_000e, q);
    n = hunts;
    ev(EV_BUSY);
    chk("hunt", 32'(n + 1), 32'(hunts));
    bus(1'b1, ADDR_EVENT_FLAGS, 32'h0000_00ff, q);
    // Freeze holds the character back, release lets it through once
    bus(1'b1, ADDR_CONTROL, 32'h0000_0007, q);
    n = fifo_n;
    fork
      tx_send('{data: 8'ha5, last_in_buf: 1'b0, clear_send_report: 1'b0});
      begin
        repeat (12) @(posedge i_clock);
        chk("frozen", 32'(n), 32'(fifo_n));
        bus(1'b1, ADDR_CONTROL, 32'h0000_0006, q);
      end
    join
    repeat (3) @(posedge i_clock);
    chk("resumed", 32'(n + 1), 32'(fifo_n));
    chk("resumed_data", 32'h0000_00a5, 32'(fifo_d));
    tx_send('{data: 8'h5a, last_in_buf: 1'b1, clear_send_report: 1'b1});
    repeat (20) @(posedge i_clock);
    rchk(ADDR_EVENT_FLAGS, 0, "tx_early");
    @(posedge i_clock) lbs <= 1'b1;
    @(posedge i_clock) lbs <= 1'b0;
    wirq();
    rchk(ADDR_EVENT_FLAGS, 32'h0000_0002, "tx_late");
    repeat (BIT_CYCLES * 3) @(posedge i_clock);
    @(negedge i_clock);
    chk("tx_gap", 0, 32'(txr));
    repeat (BIT_CYCLES * 2) @(posedge i_clock);
    @(negedge i_clock);
    chk("tx_gap_end", 1, 32'(txr));
    // Reset in mid-run wipes flags and mask
    @(posedge i_clock) i_srst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    rchk(ADDR_EVENT_FLAGS, 0, "flags_rst2");
    rchk(ADDR_EVENT_ENABLE, 0, "enable_rst2");
    stop_test();
  end
endmodule

/* File: sim/uart_far_station.sv */
// Far station model: modem lines and received-character strobes
`timescale 1ns/1ps
module uart_far_station
  import uart_evt_pkg::*;
#(
  parameter int MID_GAP = 4
)
(
  input wire logic i_clock,
  output logic o_cts_n = 1'b1,
  output logic o_cd_n = 1'b1,
  output logic o_rx_valid = 1'b0,
  output rx_char_t o_rx_char = '0,
  output logic o_rx_mid_stop = 1'b0,
  output logic o_rx_line_idle = 1'b1
);
  task flip(input int w);
    @(posedge i_clock);
    case (w)
      EV_CTS: o_cts_n <= ~o_cts_n;
      EV_CD: o_cd_n <= ~o_cd_n;
      default: o_rx_line_idle <= ~o_rx_line_idle;
    endcase
  endtask
  task send(input logic [7:0] d, input logic break_seen);
    @(posedge i_clock);
    o_rx_valid <= 1'b1;
    o_rx_char <= '{data: d, is_break: break_seen};
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_char <= ~o_rx_char; // No stale character left
    repeat (MID_GAP) @(posedge i_clock);
    o_rx_mid_stop <= 1'b1;
    @(posedge i_clock);
    o_rx_mid_stop <= 1'b0;
  endtask
endmodule
